// ---- fcs_ctrl.sv ----
// Design decisions made here: the register addresses and the APB slave port.
`timescale 1ns/100ps
// Functional notes
// - code FF puts the device in array mode for following reads.
// - code 90 then two reads give manufacturer and device signatures.
// - code 70 makes the next read return compatible status.
// - word program is 40 or 10, then data written at program address.
// - block erase is 20, then D0 written inside the target block.
// - B0 suspends erase, D0 resumes; suspend bit 6 reads 1 while suspended.
// - code 71 then read at extended address gives global or block status.
// - block lock is 77, then D0 written inside the block.
// - after power-up the controller issues upload 97 then D0.
// - status bit 7 is ready; check ready before trusting error bits.
// - controller masks reserved compatible status bits 2 to 0 in the status register copy; the read data register returns them unmasked.
// - identifier reads use address bit 0 only, other address bits zero.
module fcs_ctrl
   import fcs_pkg::*;
#(
   parameter int PH_CYCLES = PH_CYC,
   parameter int WAKE_CYCLES = WAKE_CYC
) (
   // clock and reset
   input  wire logic          clk,
   input  wire logic          rst_b,
   // apb slave
   input  wire logic [7:0]    paddr,
   input  wire logic          psel,
   input  wire logic          penable,
   input  wire logic          pwrite,
   input  wire logic [31:0]   pwdata,
   output logic               pready,
   output logic [31:0]        prdata,
   output logic               pslverr,
   // flash pins
   output logic               rp_b,
   output logic               ras_b,
   output logic               cas_b,
   output logic               oe_b,
   output logic               we_b,
   output logic [9:0]         flash_a,
   output logic [DW-1:0]      dq_out,
   output logic               dq_oe,
   input  wire logic [DW-1:0] dq_in,
   input  wire logic          ready_busy_pin
);
   typedef enum logic [1:0] {S_WAKE, S_IDLE, S_ISSUE} fcs_st_t;

   fcs_cyc_if cyc ();

   fcs_st_t       st_ff;
   fcs_op_t       op_ff;
   logic [2:0]    step_ff;
   logic [2:0]    nxt_step;
   logic          last;
   logic          fin;
   logic [AW-1:0] addr_ff;
   logic [DW-1:0] wdata_ff;
   logic [DW-1:0] rd0_ff;
   logic [DW-1:0] rd1_ff;
   logic [7:0]    csr_ff;
   logic          pd_ff;
   logic          boot_ff;
   logic          upld_ff;
   logic [3:0]    err_ff;
   logic [7:0]    wake_ff;
   logic          rb_s1_ff;
   logic          rb_s2_ff;
   logic [31:0]   prdata_ff;
   logic          pslverr_ff;
   logic          wr_en;
   logic          start;
   fcs_step_t     cur;
   fcs_step_t     ahead;

   function automatic logic needs_poll(fcs_op_t op);
      return op inside {OP_PROGRAM, OP_PROGRAM_ALT, OP_ERASE, OP_SUSPEND, OP_LOCK,
                        OP_UPLOAD};
   endfunction

   function automatic logic [7:0] first_code(fcs_op_t op);
      case (op)
         OP_READ_ARRAY:  return CD_ARRAY;
         OP_READ_ID:     return CD_IDENT;
         OP_READ_CSR:    return CD_CSR;
         OP_CLEAR:       return CD_CLEAR;
         OP_PROGRAM:     return CD_PROG;
         OP_PROGRAM_ALT: return CD_PROG2;
         OP_ERASE:       return CD_ERASE;
         OP_SUSPEND:     return CD_SUSPEND;
         OP_RESUME:      return CD_CONFIRM;
         OP_LOCK:        return CD_LOCK;
         OP_UPLOAD:      return CD_UPLOAD;
         default:        return CD_EXT;
      endcase
   endfunction

   // one bus cycle of an operation; steps 3 and 4 poll status
   function automatic fcs_step_t step_info(fcs_op_t op, logic [2:0] idx);
      fcs_step_t s;
      s = '0;
      if (idx == 3'd0) begin
         s.vld  = 1'b1;
         s.wr   = 1'b1;
         s.code = first_code(op);
      end else if (idx == 3'd1) begin
         if (op inside {OP_READ_ARRAY, OP_READ_EXT, OP_READ_CSR}) begin
            s.vld      = 1'b1;
            s.use_addr = (op != OP_READ_CSR);
         end else if (op == OP_READ_ID) begin
            s.vld = 1'b1;
         end else if (op inside {OP_PROGRAM, OP_PROGRAM_ALT}) begin
            s.vld       = 1'b1;
            s.wr        = 1'b1;
            s.use_addr  = 1'b1;
            s.use_wdata = 1'b1;
         end else if (op inside {OP_ERASE, OP_LOCK, OP_UPLOAD}) begin
            s.vld      = 1'b1;
            s.wr       = 1'b1;
            s.code     = CD_CONFIRM;
            s.use_addr = (op != OP_UPLOAD);
         end
      end else if (idx == 3'd2) begin
         s.vld = (op == OP_READ_ID);
         s.a0  = 1'b1;
      end else if (idx == STEP_POLL_CMD) begin
         s.vld  = needs_poll(op);
         s.wr   = 1'b1;
         s.code = CD_CSR;
      end else if (idx == STEP_POLL_RD) begin
         s.vld = needs_poll(op);
      end
      return s;
   endfunction

   fcs_pin_seq #(
      .PH_CYCLES(PH_CYCLES)
   ) u_seq (
      .clk     (clk),
      .rst_b   (rst_b),
      .cyc     (cyc.seq),
      .ras_b   (ras_b),
      .cas_b   (cas_b),
      .oe_b    (oe_b),
      .we_b    (we_b),
      .flash_a (flash_a),
      .dq_out  (dq_out),
      .dq_oe   (dq_oe),
      .dq_in   (dq_in)
   );

   // request to the pin sequencer
   assign cur       = step_info(op_ff, step_ff);
   assign cyc.req   = (st_ff == S_ISSUE);
   assign cyc.we    = cur.wr;
   assign cyc.addr  = cur.use_addr ? addr_ff : {19'h00000, cur.a0};
   assign cyc.wdata = cur.use_wdata ? wdata_ff : {8'h00, cur.code};

   always_comb begin
      nxt_step = step_ff + 3'd1;
      ahead    = step_info(op_ff, nxt_step);
      if (!ahead.vld && needs_poll(op_ff) && step_ff < STEP_POLL_CMD) begin
         nxt_step = STEP_POLL_CMD;
         ahead    = step_info(op_ff, nxt_step);
      end
      if (step_ff == STEP_POLL_RD) begin
         nxt_step = STEP_POLL_RD;
      end
      // poll ends only when both status bit and pin say ready
      if (step_ff == STEP_POLL_RD) begin
         last = cyc.rdata[CSR_READY] && rb_s2_ff;
      end else begin
         last = !ahead.vld;
      end
   end

   assign fin = (st_ff == S_ISSUE) && cyc.ack && last;

   // apb
   assign pready  = 1'b1;
   assign prdata  = prdata_ff;
   assign pslverr = pslverr_ff;
   assign wr_en   = psel && penable && pwrite;
   assign start   = wr_en && paddr == OFF_CMD && st_ff == S_IDLE && !boot_ff
                    && pwdata[3:0] <= OP_LAST && !pd_ff;

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         rb_s1_ff <= 1'b0;
         rb_s2_ff <= 1'b0;
      end else begin
         rb_s1_ff <= ready_busy_pin;
         rb_s2_ff <= rb_s1_ff;
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         addr_ff  <= RST_ADDR;
         wdata_ff <= RST_WDATA;
         pd_ff    <= 1'b0;
      end else if (wr_en && st_ff != S_ISSUE) begin
         if (paddr == OFF_ADDR) begin
            addr_ff <= pwdata[AW-1:0];
         end else if (paddr == OFF_WDATA) begin
            wdata_ff <= pwdata[DW-1:0];
         end else if (paddr == OFF_CTRL) begin
            pd_ff <= pwdata[0];
         end
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         prdata_ff  <= '0;
         pslverr_ff <= 1'b0;
      end else if (psel && !penable) begin
         pslverr_ff <= 1'b0;
         prdata_ff  <= '0;
         if (paddr == OFF_CMD || paddr == OFF_ADDR) begin
            prdata_ff <= (paddr == OFF_CMD) ? {28'h0000000, op_ff} : {12'h000, addr_ff};
         end else if (paddr == OFF_WDATA) begin
            prdata_ff <= {16'h0000, wdata_ff};
         end else if (paddr == OFF_STAT) begin
            prdata_ff <= {12'h000, op_ff, csr_ff, csr_ff[CSR_ESUSP], err_ff, upld_ff,
                          rb_s2_ff, st_ff != S_IDLE || boot_ff};
         end else if (paddr == OFF_RDATA) begin
            prdata_ff <= {rd1_ff, rd0_ff};
         end else if (paddr == OFF_CTRL) begin
            prdata_ff <= {31'h00000000, pd_ff};
         end else begin
            pslverr_ff <= 1'b1;
         end
      end
   end

   // power-down pin; entering it relocks every block so upload runs again on leaving
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         rp_b    <= 1'b0;
         boot_ff <= 1'b1;
         wake_ff <= '0;
      end else begin
         rp_b <= !pd_ff;
         if (pd_ff) begin
            boot_ff <= 1'b1;
            wake_ff <= '0;
         end else if (wake_ff != 8'(WAKE_CYCLES)) begin
            wake_ff <= wake_ff + 8'h01;
         end
         if (st_ff == S_IDLE && boot_ff && !pd_ff && wake_ff == 8'(WAKE_CYCLES)) begin
            boot_ff <= 1'b0;
         end
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         st_ff   <= S_WAKE;
         op_ff   <= OP_READ_ARRAY;
         step_ff <= '0;
      end else begin
         case (st_ff)
            S_WAKE: begin
               if (wake_ff == 8'(WAKE_CYCLES)) begin
                  st_ff <= S_IDLE;
               end
            end
            S_IDLE: begin
               step_ff <= '0;
               if (boot_ff && !pd_ff && wake_ff == 8'(WAKE_CYCLES)) begin
                  op_ff <= OP_UPLOAD;
                  st_ff <= S_ISSUE;
               end else if (start) begin
                  op_ff <= fcs_op_t'(pwdata[3:0]);
                  st_ff <= S_ISSUE;
               end
            end
            default: begin
               if (cyc.ack) begin
                  step_ff <= nxt_step;
                  if (last) begin
                     st_ff <= S_IDLE;
                  end
               end
            end
         endcase
      end
   end

   // read results; the poll masks reserved status bits
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         rd0_ff <= '0;
         rd1_ff <= '0;
         csr_ff <= RST_CSR;
      end else if (st_ff == S_ISSUE && cyc.ack && !cur.wr) begin
         if (step_ff == STEP_POLL_RD || op_ff == OP_READ_CSR) begin
            csr_ff <= cyc.rdata[7:0] & CSR_MASK;
         end
         if (step_ff == 3'd2) begin
            rd1_ff <= cyc.rdata;
         end else begin
            rd0_ff <= cyc.rdata;
         end
      end
   end

   // error flags taken only once ready is seen; cleared by the clear op
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         err_ff  <= '0;
         upld_ff <= 1'b0;
      end else begin
         if (fin && step_ff == STEP_POLL_RD) begin
            err_ff[ST_EERR-ST_EERR]   <= cyc.rdata[CSR_EERR];
            err_ff[ST_PERR-ST_EERR]   <= cyc.rdata[CSR_PERR];
            err_ff[ST_VERR-ST_EERR]   <= cyc.rdata[CSR_VERR];
            err_ff[ST_SEQERR-ST_EERR] <= cyc.rdata[CSR_EERR] && cyc.rdata[CSR_PERR];
         end else if (fin && op_ff == OP_CLEAR) begin
            err_ff <= '0;
         end
         if (fin && op_ff == OP_UPLOAD) begin
            upld_ff <= 1'b1;
         end else if (pd_ff) begin
            upld_ff <= 1'b0;
         end
      end
   end

   upper_byte_zero_a: assert property (@(posedge clk) disable iff (!rst_b)
      cyc.req && cyc.we && !cur.use_wdata |-> cyc.wdata[15:8] == 8'h00)
      else $error("command write with nonzero upper byte");
   array_code_a: assert property (@(posedge clk) disable iff (!rst_b)
      cyc.req && op_ff == OP_READ_ARRAY && step_ff == 3'd0 |-> cyc.wdata == 16'h00ff)
      else $error("array read without array code");
   id_address_a: assert property (@(posedge clk) disable iff (!rst_b)
      cyc.req && op_ff == OP_READ_ID && step_ff != 3'd0
      |-> cyc.addr == {19'h00000, step_ff == 3'd2})
      else $error("identifier read at wrong address");
   program_data_a: assert property (@(posedge clk) disable iff (!rst_b)
      cyc.req && op_ff inside {OP_PROGRAM, OP_PROGRAM_ALT} && step_ff == 3'd1
      |-> cyc.we && cyc.wdata == wdata_ff && cyc.addr == addr_ff)
      else $error("program data cycle malformed");
   confirm_code_a: assert property (@(posedge clk) disable iff (!rst_b)
      cyc.req && op_ff inside {OP_ERASE, OP_LOCK, OP_UPLOAD} && step_ff == 3'd1
      |-> cyc.we && cyc.wdata == 16'h00d0)
      else $error("confirm cycle without confirm code");
   boot_upload_a: assert property (@(posedge clk) disable iff (!rst_b)
      $fell(boot_ff) |=> st_ff == S_ISSUE && op_ff == OP_UPLOAD && cyc.wdata == 16'h0097)
      else $error("upload not issued at start");
   poll_ready_a: assert property (@(posedge clk) disable iff (!rst_b)
      fin && step_ff == STEP_POLL_RD |-> cyc.rdata[7] && rb_s2_ff)
      else $error("poll ended before ready");
   csr_masked_a: assert property (@(posedge clk) disable iff (!rst_b)
      st_ff == S_ISSUE && cyc.ack && step_ff == STEP_POLL_RD
      |=> csr_ff == (($past(cyc.rdata) & 16'h00f8)))
      else $error("reserved status bits not masked");
   busy_ignore_a: assert property (@(posedge clk) disable iff (!rst_b)
      st_ff == S_ISSUE && !cyc.ack |=> $stable(op_ff) && $stable(step_ff))
      else $error("operation changed while issuing");

   prog_done_c: cover property (@(posedge clk) disable iff (!rst_b)
      fin && op_ff == OP_PROGRAM);
   erase_done_c: cover property (@(posedge clk) disable iff (!rst_b)
      fin && op_ff == OP_ERASE);
   id_read_c: cover property (@(posedge clk) disable iff (!rst_b)
      fin && op_ff == OP_READ_ID);
   poll_repeat_c: cover property (@(posedge clk) disable iff (!rst_b)
      st_ff == S_ISSUE && cyc.ack && step_ff == STEP_POLL_RD && !last);
endmodule

// ---- fcs_ctrl_test.sv ----
`timescale 1ns/100ps
module fcs_ctrl_test;
   import fcs_pkg::*;
   logic        clk, rst_b, psel, penable, pwrite, pready, pslverr, err;
   logic        rp_b, ras_b, cas_b, oe_b, we_b, dq_oe, rb;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, q;
   logic [9:0]  fa;
   logic [15:0] dqo, dqi;
   int          error_cnt, tests_run, cyc;
   fcs_ctrl #(.WAKE_CYCLES(1)) dut_u (.clk(clk), .rst_b(rst_b), .paddr(paddr), .psel(psel),
      .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pready(pready), .prdata(prdata),
      .pslverr(pslverr), .rp_b(rp_b), .ras_b(ras_b), .cas_b(cas_b), .oe_b(oe_b), .we_b(we_b),
      .flash_a(fa), .dq_out(dqo), .dq_oe(dq_oe), .dq_in(dqi), .ready_busy_pin(rb));
   fcs_flash_model #(.BUSY_NS(1000)) dev_u (.clk(clk), .rp_b(rp_b), .ras_b(ras_b),
      .cas_b(cas_b), .oe_b(oe_b),
      .we_b(we_b), .flash_a(fa), .dq_out(dqo), .dq_in(dqi), .ready_busy_pin(rb));
   task chk(input string n, input logic [31:0] s, input logic [31:0] e);
      tests_run++;
      if (s !== e) begin
         error_cnt++;
         $display("MISMATCH %s expected %h seen %h", n, e, s);
      end
   endtask
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      psel <= 1;
      paddr <= a;
      pwrite <= w;
      pwdata <= d;
      @(posedge clk);
      penable <= 1;
      do @(posedge clk); while (pready !== 1'b1);
      q = prdata;
      err = pslverr;
      psel <= 0;
      penable <= 0;
   endtask
   task run(input logic [3:0] op);
      apb(1, OFF_CMD, {28'h0, op});
      for (int i = 0; i < 200; i++) begin
         apb(0, OFF_STAT, 0);
         if (q[ST_BUSY] === 1'b0 && q[ST_UPLD] === 1'b1) break;
      end
   endtask
   task set(input logic [19:0] a);
      apb(1, OFF_ADDR, {12'h0, a});
      apb(1, OFF_WDATA, 32'h0000beef);
   endtask
   task t_prog;
      set(20'h12345);
      run(4);
      chk("pdata", dev_u.pd, 16'hbeef);
      chk("paddr", dev_u.pa, 20'h12345);
      chk("csr", q[15:8], 8'h80);
      dev_u.fail_next = 1;
      dev_u.vpp_bad = 1;
      run(5);
      chk("perr", q[ST_PERR], 1);
      chk("verr", q[ST_VERR], 1);
      dev_u.fail_next = 0;
      dev_u.vpp_bad = 0;
      run(3);
      chk("clr", q[ST_PERR], 0);
      chk("vclr", q[ST_VERR], 0);
      run(2);
      apb(0, OFF_RDATA, 0);
      chk("rdcsr", q[7:0] & CSR_MASK, 8'h80);
   endtask
   task t_erase;
      set(20'h48000);
      run(6);
      chk("eaddr", dev_u.pa, 20'h48000);
      chk("eerr", q[ST_SEQERR:ST_EERR], 0);
      set(20'h50010);
      run(9);
      chk("laddr", dev_u.pa, 20'h50010);
      run(7);
      chk("susp", q[ST_ESUSP], 1);
      run(8);
      chk("resume", dev_u.compatible_status[6], 0);
   endtask
   task t_read;
      run(1);
      apb(0, OFF_RDATA, 0);
      chk("ident", q, {dev_u.DEV_ID, dev_u.MFR_ID});
      set(20'h00000);
      run(11);
      apb(0, OFF_RDATA, 0);
      chk("ext", q[15:0], 16'h00c2);
      set(20'h00abc);
      run(0);
      apb(0, OFF_RDATA, 0);
      chk("array", q[15:0], 16'h50e6);
      apb(0, 8'h20, 0);
      chk("slverr", err, 1);
   endtask
   task t_pdown;
      apb(1, OFF_CTRL, 1);
      apb(0, OFF_CTRL, 0);
      chk("pdbit", q[0], 1);
      chk("rp", rp_b, 0);
      chk("relock", dev_u.locked, 1);
      apb(1, OFF_CTRL, 0);
      run(2);
      chk("reload", q[ST_UPLD], 1);
      chk("unlock2", dev_u.locked, 0);
   endtask
   task finish_test;
      $display("checks %0d mismatches %0d", tests_run, error_cnt);
      if (error_cnt == 0 && tests_run > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   initial begin
      clk = 0;
      forever #5 clk = ~clk;
   end
   // generous ceiling: each poll waits out a busy time of about 100 cycles
   always @(posedge clk) begin
      cyc++;
      if (cyc == 40000) begin
         error_cnt++;
         finish_test;
      end
   end
   initial begin
      {rst_b, psel, penable, pwrite, paddr, pwdata, error_cnt, tests_run, cyc} = 0;
      repeat (4) @(posedge clk);
      chk("locked", dev_u.locked, 1);
      rst_b <= 1;
      run(2);
      chk("upload", q[ST_UPLD], 1);
      chk("unlocked", dev_u.locked, 0);
      t_prog;
      t_erase;
      t_read;
      t_pdown;
      finish_test;
   end
endmodule

// ---- fcs_cyc_if.sv ----
`timescale 1ns/100ps
interface fcs_cyc_if;
   logic          req;
   logic          we;
   logic [19:0]   addr;
   logic [15:0]   wdata;
   logic          ack;
   logic [15:0]   rdata;

   modport ctrl (output req, output we, output addr, output wdata, input ack, input rdata);
   modport seq  (input req, input we, input addr, input wdata, output ack, output rdata);
endinterface

// ---- fcs_flash_model.sv ----
`timescale 1ns/100ps
module fcs_flash_model #(
   parameter logic [15:0] MFR_ID  = 16'h1357, // arbitrary value
   parameter logic [15:0] DEV_ID  = 16'h2468, // arbitrary value
   parameter int          BUSY_NS = 200
) (
   // timer clock
   input  wire logic        clk,
   // flash pins
   input  wire logic        rp_b,
   input  wire logic        ras_b,
   input  wire logic        cas_b,
   input  wire logic        oe_b,
   input  wire logic        we_b,
   input  wire logic [9:0]  flash_a,
   input  wire logic [15:0] dq_out,
   output logic [15:0]      dq_in,
   output logic             ready_busy_pin
);
   logic [19:0] adr, pa;
   logic [15:0] pd, rd, lst;
   logic [7:0]  pend, compatible_status, c;
   logic [1:0]  md;
   logic        rdy, locked, fail_next, vpp_bad;
   time         t_end;
   initial begin
      rdy = 1;
      t_end = 0;
      fail_next = 0;
      vpp_bad = 0;
      lst = 0;
   end
   always @(negedge ras_b) adr[19:10] = flash_a;
   always @(negedge cas_b) adr[9:0] = flash_a;
   always @(posedge clk) begin
      rdy <= $time >= t_end;
      if (!rp_b) begin
         md = 0;
         pend = 0;
         compatible_status = 0;
         locked = 1;
      end
   end
   assign ready_busy_pin = rdy | !rp_b;
   // reserved status bits read nonzero so masking is visible
   always @* case (md)
      2'd0: rd = adr[15:0] ^ 16'h5a5a;
      2'd1: rd = adr[0] ? DEV_ID : MFR_ID;
      2'd2: rd = {8'h0, rdy, compatible_status[6:3], 3'b101};
      default: rd = {8'h0, rdy, !locked, compatible_status[5], 2'b00, compatible_status[3], 2'b10};
   endcase
   // released bus shows the inverse of the last word
   assign dq_in = oe_b ? ~lst : rd;
   always @(posedge oe_b) lst = rd;
   always @(posedge we_b) begin
      c = dq_out[7:0];
      if (pend != 0) begin
         if (pend == 8'h20 && c != 8'hd0) compatible_status[5:4] = 2'b11;
         else begin
            t_end = $time + BUSY_NS;
            compatible_status[4] = fail_next;
            if (pend != 8'h77 && pend != 8'h97) compatible_status[3] = vpp_bad;
            if (pend == 8'h97) locked = 0;
         end
         pd = dq_out;
         pa = adr;
         pend = 0;
      end else case (c)
         8'hff: md = 0;
         8'h90: md = 1;
         8'h70: md = 2;
         8'h71: md = 3;
         8'h50: compatible_status[5:3] = 0;
         8'hb0: compatible_status[6] = 1;
         8'hd0: compatible_status[6] = 0;
         default: begin
            pend = c;
            md = 2;
         end
      endcase
   end
endmodule

// ---- fcs_pin_seq.sv ----
`timescale 1ns/100ps
module fcs_pin_seq
   import fcs_pkg::*;
#(
   parameter int PH_CYCLES = PH_CYC
) (
   // clock and reset
   input  wire logic          clk,
   input  wire logic          rst_b,
   // cycle requests
   fcs_cyc_if.seq             cyc,
   // flash pins
   output logic               ras_b,
   output logic               cas_b,
   output logic               oe_b,
   output logic               we_b,
   output logic [9:0]         flash_a,
   output logic [DW-1:0]      dq_out,
   output logic               dq_oe,
   input  wire logic [DW-1:0] dq_in
);
   typedef enum logic [2:0] {P_IDLE, P_ROW, P_COL, P_DATA, P_END} fcs_pst_t;

   fcs_pst_t      pst_ff;
   logic [7:0]    cnt_ff;
   logic          we_ff;
   logic [9:0]    col_ff;
   logic [DW-1:0] dq_s1_ff;
   logic [DW-1:0] dq_s2_ff;
   logic [DW-1:0] rdata_ff;
   logic          ack_ff;
   logic          expired;

   // data phase is two cycles longer so the synchroniser has settled;
   // column phase one longer since the column goes out a cycle after ras falls
   assign expired   = (pst_ff == P_DATA) ? (cnt_ff == 8'(PH_CYCLES + 1))
                    : (pst_ff == P_COL)  ? (cnt_ff == 8'(PH_CYCLES))
                                         : (cnt_ff == 8'(PH_CYCLES - 1));
   assign cyc.ack   = ack_ff;
   assign cyc.rdata = rdata_ff;

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         dq_s1_ff <= '0;
         dq_s2_ff <= '0;
      end else begin
         dq_s1_ff <= dq_in;
         dq_s2_ff <= dq_s1_ff;
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         pst_ff <= P_IDLE;
         cnt_ff <= '0;
         ack_ff <= 1'b0;
      end else begin
         ack_ff <= 1'b0;
         cnt_ff <= expired ? 8'h00 : cnt_ff + 8'h01;
         case (pst_ff)
            P_IDLE: begin
               cnt_ff <= '0;
               if (cyc.req && !ack_ff) begin
                  pst_ff <= P_ROW;
               end
            end
            P_ROW:  if (expired) pst_ff <= P_COL;
            P_COL:  if (expired) pst_ff <= P_DATA;
            P_DATA: if (expired) pst_ff <= P_END;
            default: begin
               if (expired) begin
                  pst_ff <= P_IDLE;
                  ack_ff <= 1'b1;
               end
            end
         endcase
      end
   end

   // pins: row latched on ras fall, column on cas fall, ras always first
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         ras_b    <= 1'b1;
         cas_b    <= 1'b1;
         oe_b     <= 1'b1;
         we_b     <= 1'b1;
         flash_a  <= '0;
         dq_out   <= '0;
         dq_oe    <= 1'b0;
         we_ff    <= 1'b0;
         col_ff   <= '0;
         rdata_ff <= '0;
      end else begin
         if (pst_ff == P_IDLE && cyc.req && !ack_ff) begin
            we_ff   <= cyc.we;
            flash_a <= cyc.addr[19:10];
            col_ff  <= cyc.addr[9:0];
            dq_out  <= cyc.wdata;
         end
         if (pst_ff == P_ROW && expired) begin
            ras_b <= 1'b0;
         end
         // row must hold past the ras fall
         if (pst_ff == P_COL && cnt_ff == 8'h00) begin
            flash_a <= col_ff;
         end
         if (pst_ff == P_COL && expired) begin
            cas_b <= 1'b0;
            we_b  <= !we_ff;
            oe_b  <= we_ff;
            dq_oe <= we_ff;
         end
         if (pst_ff == P_DATA && expired) begin
            if (!we_ff) begin
               rdata_ff <= dq_s2_ff;
            end
            ras_b <= 1'b1;
            cas_b <= 1'b1;
            oe_b  <= 1'b1;
            we_b  <= 1'b1;
         end
         if (pst_ff == P_END) begin
            dq_oe <= 1'b0;
         end
      end
   end

   cas_after_ras_a: assert property (@(posedge clk) disable iff (!rst_b)
      $fell(cas_b) |-> !ras_b) else $error("column strobe fell without row strobe");
   row_hold_a: assert property (@(posedge clk) disable iff (!rst_b)
      $fell(ras_b) |-> $stable(flash_a)) else $error("row address moved at row strobe");
   no_fight_a: assert property (@(posedge clk) disable iff (!rst_b)
      dq_oe |-> oe_b) else $error("data driven while output enabled");
   cycle_ends_a: assert property (@(posedge clk) disable iff (!rst_b)
      $rose(cyc.req) |-> ##[1:60] ack_ff) else $error("pin cycle never finished");
endmodule

// ---- fcs_pkg.sv ----
package fcs_pkg;

   // widths of the flash side
   localparam int AW = 20;
   localparam int DW = 16;

   // register offsets on the apb side
   localparam logic [7:0] OFF_CMD   = 8'h00;
   localparam logic [7:0] OFF_ADDR  = 8'h04;
   localparam logic [7:0] OFF_WDATA = 8'h08;
   localparam logic [7:0] OFF_STAT  = 8'h0c;
   localparam logic [7:0] OFF_RDATA = 8'h10;
   localparam logic [7:0] OFF_CTRL  = 8'h14;

   // reset values
   localparam logic [AW-1:0] RST_ADDR  = 20'h00000;
   localparam logic [DW-1:0] RST_WDATA = 16'h0000;
   localparam logic [7:0]    RST_CSR   = 8'h00;

   // command codes, low byte only
   localparam logic [7:0] CD_ARRAY   = 8'hff;
   localparam logic [7:0] CD_IDENT   = 8'h90;
   localparam logic [7:0] CD_CSR     = 8'h70;
   localparam logic [7:0] CD_CLEAR   = 8'h50;
   localparam logic [7:0] CD_PROG    = 8'h40;
   localparam logic [7:0] CD_PROG2   = 8'h10;
   localparam logic [7:0] CD_ERASE   = 8'h20;
   localparam logic [7:0] CD_CONFIRM = 8'hd0;
   localparam logic [7:0] CD_SUSPEND = 8'hb0;
   localparam logic [7:0] CD_EXT     = 8'h71;
   localparam logic [7:0] CD_LOCK    = 8'h77;
   localparam logic [7:0] CD_UPLOAD  = 8'h97;

   // compatible status fields
   localparam int CSR_READY = 7;
   localparam int CSR_ESUSP = 6;
   localparam int CSR_EERR  = 5;
   localparam int CSR_PERR  = 4;
   localparam int CSR_VERR  = 3;
   localparam logic [7:0] CSR_MASK = 8'hf8;

   // status register fields
   localparam int ST_BUSY = 0;
   localparam int ST_RBPIN = 1;
   localparam int ST_UPLD = 2;
   localparam int ST_EERR = 3;
   localparam int ST_PERR = 4;
   localparam int ST_VERR = 5;
   localparam int ST_SEQERR = 6;
   localparam int ST_ESUSP = 7;
   localparam int ST_CSR_LSB = 8;
   localparam int ST_OP_LSB = 16;

   // timing counts in clk cycles
   localparam int PH_CYC   = 2;
   localparam int WAKE_CYC = 4;

   // steps 3 and 4 form the status poll
   localparam logic [2:0] STEP_POLL_CMD = 3'd3;
   localparam logic [2:0] STEP_POLL_RD  = 3'd4;

   typedef enum logic [3:0] {
      OP_READ_ARRAY, OP_READ_ID, OP_READ_CSR, OP_CLEAR, OP_PROGRAM, OP_PROGRAM_ALT,
      OP_ERASE, OP_SUSPEND, OP_RESUME, OP_LOCK, OP_UPLOAD, OP_READ_EXT
   } fcs_op_t;
   localparam logic [3:0] OP_LAST = 4'hb;

   typedef struct packed {
      logic       vld;
      logic       wr;
      logic [7:0] code;
      logic       use_addr;
      logic       use_wdata;
      logic       a0;
   } fcs_step_t;

endpackage
